//--- include/clock_gen_pkg.sv
package clock_gen_pkg;

    // ----------------------------------------
    // register addresses
    // ----------------------------------------
    localparam logic [7:0] addr_reference_divider_ratio    = 8'h00;
    localparam logic [7:0] addr_feedback_divider_byte_one  = 8'h01;
    localparam logic [7:0] addr_feedback_divider_byte_two  = 8'h02;
    localparam logic [7:0] addr_output_divider_a_ratio     = 8'h03;
    localparam logic [7:0] addr_output_divider_b_ratio     = 8'h04;
    localparam logic [7:0] addr_output_and_input_control   = 8'h05;
    localparam logic [7:0] addr_holdover_and_reset_control = 8'h06;
    localparam logic [7:0] addr_monitor_status             = 8'h07;
    localparam logic [7:0] addr_reserved_slot              = 8'h08;
    localparam logic [7:0] three_wire_addr_mask            = 8'h7f;

    // ----------------------------------------
    // reset values
    // ----------------------------------------
    localparam logic [7:0] rst_divider                     = 8'h00;
    localparam logic [7:0] rst_output_and_input_control    = 8'h60;
    localparam logic [7:0] rst_holdover_and_reset_control  = 8'h00;
    localparam logic [7:0] rst_monitor_status              = 8'h00;

    // ----------------------------------------
    // field positions
    // ----------------------------------------
    localparam int pos_out_disable     = 7;
    localparam int pos_enable_a        = 6;
    localparam int pos_enable_b        = 5;
    localparam int pos_default_input   = 4;
    localparam int pos_input_enable_hi = 3;
    localparam int pos_input_enable_lo = 2;
    localparam int pos_revert          = 1;
    localparam int pos_monitor_reset   = 0;
    localparam int pos_holdover_enable = 7;
    localparam int pos_forced_holdover = 6;
    localparam int pos_acquire_freq    = 5;
    localparam int pos_soft_reset      = 4;
    localparam int pos_fixed_zero      = 3;
    localparam int pos_aux_source      = 2;
    localparam int pos_acquire_select  = 1;
    localparam int pos_alert           = 7;
    localparam int pos_fail_a          = 6;
    localparam int pos_fail_b          = 5;
    localparam int pos_active_input    = 4;
    localparam int pos_unlocked        = 3;
    localparam int pos_holdover        = 2;

    localparam logic [7:0] out_divider_code_mask = 8'he0;
    localparam logic [7:0] feedback_byte_two_mask = 8'hfe;
    localparam logic [7:0] control_b_mask        = 8'hf6;
    localparam logic [1:0] input_enable_pins     = 2'b00;
    localparam logic [1:0] input_enable_a_only   = 2'b01;
    localparam logic [1:0] input_enable_b_only   = 2'b10;
    localparam int freq_width                    = 16;
    localparam int pin_count                     = 9;

    // ----------------------------------------
    // types
    // ----------------------------------------
    typedef enum logic [1:0] {
        mon_use_a,
        mon_use_b,
        mon_holdover
    } monitor_state_type;

    typedef struct packed {
        logic [7:0] ref_div;
        logic [7:0] fb_one;
        logic [7:0] fb_two;
        logic [7:0] out_a;
        logic [7:0] out_b;
        logic [7:0] ctrl_a;
        logic [7:0] ctrl_b;
    } reg_file_type;

    typedef struct packed {
        logic [7:0] addr;
        logic       wr;
        logic       rd;
        logic [7:0] wdata;
    } reg_access_type;

    typedef struct packed {
        logic [8:0]            ref_ratio;
        logic [15:0]           feedback_ratio;
        logic [4:0]            out_a_ratio;
        logic [4:0]            out_b_ratio;
        logic                  ref_a_enabled;
        logic                  ref_b_enabled;
        logic                  use_ref_b;
        logic                  holdover;
        logic                  hold_value_select;
        logic [freq_width-1:0] nominal_freq;
    } pll_control_type;

    // ----------------------------------------
    // decoding
    // ----------------------------------------
    function automatic logic [4:0] out_ratio(input logic [2:0] code);
        case (code)
            3'h6:    out_ratio = 5'h08;
            3'h7:    out_ratio = 5'h10;
            default: out_ratio = 5'({2'h0, code} + 5'h01);
        endcase
    endfunction : out_ratio

endpackage : clock_gen_pkg

//--- design/pin_sync.sv
`timescale 1ns/10ps
module pin_sync #(
    parameter int width = 1
) (
    input  wire logic             clock_in,
    input  wire logic             rst_in,
    input  wire logic [width-1:0] async_in,
    output logic      [width-1:0] sync_out
);

    // ----------------------------------------
    // two-stage synchroniser
    // ----------------------------------------
    // first stage feeds only the second one
    logic [width-1:0] stage_one;

    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            stage_one <= '0;
            sync_out  <= '0;
        end else begin
            stage_one <= async_in;
            sync_out  <= stage_one;
        end
    end

endmodule : pin_sync

//--- design/clock_gen_config_status_regs.sv
`timescale 1ns/10ps
module clock_gen_config_status_regs (
    input  wire logic                                   clock_in,
    input  wire logic                                   rst_in,
    input  wire clock_gen_pkg::reg_access_type          access_in,
    input  wire logic                                   three_wire_mode_in,
    output logic [7:0]                                  read_data_out,
    output logic                                        read_valid_out,
    input  wire logic                                   master_reset_pin_in,
    input  wire logic                                   select_pin_a_in,
    input  wire logic                                   select_pin_b_in,
    input  wire logic                                   ref_input_a_fail_in,
    input  wire logic                                   ref_input_b_fail_in,
    input  wire logic                                   pll_unlocked_in,
    input  wire logic                                   divider_out_a_in,
    input  wire logic                                   divider_out_b_in,
    input  wire logic [clock_gen_pkg::freq_width-1:0]   vcxo_freq_in,
    output clock_gen_pkg::pll_control_type              pll_control_out,
    output logic                                        clock_output_a_out,
    output logic                                        clock_output_a_oe_out,
    output logic                                        clock_output_b_out,
    output logic                                        clock_output_b_oe_out,
    output logic                                        clock_output_aux_out,
    output logic                                        failure_alert_out,
    output logic                                        chip_reset_out
);
    import clock_gen_pkg::*;

    // ----------------------------------------
    // state
    // ----------------------------------------
    typedef struct packed {
        reg_file_type          regs;
        logic                  prev_forced;
        logic                  prev_acquire;
        logic                  fail_a;
        logic                  fail_b;
        logic                  alert;
        monitor_state_type     mon;
        logic [freq_width-1:0] nominal;
        logic [7:0]            rdata;
        logic                  rvalid;
        logic                  clk_a;
        logic                  clk_a_oe;
        logic                  clk_b;
        logic                  clk_b_oe;
        logic                  clk_aux;
    } state_type;

    localparam state_type state_reset = '{
        regs: '{
            ref_div: rst_divider,
            fb_one:  rst_divider,
            fb_two:  rst_divider,
            out_a:   rst_divider,
            out_b:   rst_divider,
            ctrl_a:  rst_output_and_input_control,
            ctrl_b:  rst_holdover_and_reset_control
        },
        prev_forced:  1'b0,
        prev_acquire: 1'b0,
        fail_a:       1'b0,
        fail_b:       1'b0,
        alert:        1'b0,
        mon:          mon_use_a,
        nominal:      '0,
        rdata:        8'h00,
        rvalid:       1'b0,
        clk_a:        1'b0,
        // outputs come out of reset enabled, matching the control reset value
        clk_a_oe:     rst_output_and_input_control[pos_enable_a],
        clk_b:        1'b0,
        clk_b_oe:     rst_output_and_input_control[pos_enable_b],
        clk_aux:      1'b0
    };

    state_type state;
    state_type next_state;

    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    logic [pin_count-1:0] pins_raw;
    logic [pin_count-1:0] pins;

    assign pins_raw = {three_wire_mode_in, master_reset_pin_in, select_pin_a_in, select_pin_b_in,
                       ref_input_a_fail_in, ref_input_b_fail_in, pll_unlocked_in,
                       divider_out_a_in, divider_out_b_in};

    pin_sync #(
        .width    (pin_count)
    ) u_pin_sync (
        .clock_in (clock_in),
        .rst_in   (rst_in),
        .async_in (pins_raw),
        .sync_out (pins)
    );

    logic three_wire;
    logic mr_pin;
    logic sel_a;
    logic sel_b;
    logic fail_a_pin;
    logic fail_b_pin;
    logic unlocked;
    logic div_a;
    logic div_b;

    assign {three_wire, mr_pin, sel_a, sel_b, fail_a_pin, fail_b_pin, unlocked, div_a, div_b} = pins;

    // ----------------------------------------
    // register bus decode
    // ----------------------------------------
    logic [7:0] eff_addr;
    logic [7:0] status_byte;

    always_comb begin
        eff_addr = access_in.addr;
        if (three_wire) begin
            eff_addr = access_in.addr & three_wire_addr_mask;
        end
    end

    always_comb begin
        status_byte                   = rst_monitor_status;
        status_byte[pos_alert]        = state.alert;
        status_byte[pos_fail_a]       = state.fail_a;
        status_byte[pos_fail_b]       = state.fail_b;
        status_byte[pos_active_input] = (state.mon == mon_use_b);
        status_byte[pos_unlocked]     = unlocked;
        status_byte[pos_holdover]     = (state.mon == mon_holdover);
    end

    // ----------------------------------------
    // next-state logic
    // ----------------------------------------
    logic       ref_a_on;
    logic       ref_b_on;
    logic       default_b;
    logic       revert;
    logic       hold_enable;
    logic       forced;
    logic       acquire;
    logic       monitor_reset;
    logic       capture;
    logic       out_disable;
    logic [1:0] input_enable;

    always_comb begin
        next_state    = state;
        next_state.rvalid = 1'b0;
        out_disable   = state.regs.ctrl_a[pos_out_disable];
        default_b     = state.regs.ctrl_a[pos_default_input];
        input_enable  = state.regs.ctrl_a[pos_input_enable_hi:pos_input_enable_lo];
        revert        = state.regs.ctrl_a[pos_revert];
        hold_enable   = state.regs.ctrl_b[pos_holdover_enable];
        forced        = state.regs.ctrl_b[pos_forced_holdover];
        acquire       = state.regs.ctrl_b[pos_acquire_freq];
        monitor_reset = 1'b0;

        // input enable field
        case (input_enable)
            input_enable_pins: begin
                ref_a_on = sel_a;
                ref_b_on = sel_b;
            end
            input_enable_a_only: begin
                ref_a_on = 1'b1;
                ref_b_on = 1'b0;
            end
            input_enable_b_only: begin
                ref_a_on = 1'b0;
                ref_b_on = 1'b1;
            end
            default: begin
                ref_a_on = 1'b1;
                ref_b_on = 1'b1;
            end
        endcase

        // host accesses
        if (access_in.wr) begin
            case (eff_addr)
                addr_reference_divider_ratio:   next_state.regs.ref_div = access_in.wdata;
                addr_feedback_divider_byte_one: next_state.regs.fb_one  = access_in.wdata;
                addr_feedback_divider_byte_two: next_state.regs.fb_two  = access_in.wdata & feedback_byte_two_mask;
                addr_output_divider_a_ratio:    next_state.regs.out_a   = access_in.wdata & out_divider_code_mask;
                addr_output_divider_b_ratio:    next_state.regs.out_b   = access_in.wdata & out_divider_code_mask;
                addr_output_and_input_control: begin
                    // monitor reset is a strobe and is not stored
                    next_state.regs.ctrl_a = access_in.wdata;
                    next_state.regs.ctrl_a[pos_monitor_reset] = 1'b0;
                    monitor_reset = access_in.wdata[pos_monitor_reset] & access_in.wdata[pos_revert];
                end
                addr_holdover_and_reset_control: begin
                    // fixed-zero bit is masked and stored as zero whatever the host writes
                    next_state.regs.ctrl_b = access_in.wdata & control_b_mask;
                end
                default: begin
                    // status, reserved slot and unmapped addresses ignore writes
                    next_state.regs = state.regs;
                end
            endcase
        end
        if (access_in.rd) begin
            next_state.rvalid = 1'b1;
            case (eff_addr)
                addr_reference_divider_ratio:    next_state.rdata = state.regs.ref_div;
                addr_feedback_divider_byte_one:  next_state.rdata = state.regs.fb_one;
                addr_feedback_divider_byte_two:  next_state.rdata = state.regs.fb_two;
                addr_output_divider_a_ratio:     next_state.rdata = state.regs.out_a;
                addr_output_divider_b_ratio:     next_state.rdata = state.regs.out_b;
                addr_output_and_input_control:   next_state.rdata = state.regs.ctrl_a;
                addr_holdover_and_reset_control: next_state.rdata = state.regs.ctrl_b;
                addr_monitor_status:             next_state.rdata = status_byte;
                default:                         next_state.rdata = 8'h00;
            endcase
        end

        // frequency capture on rising edges of stored bits
        next_state.prev_forced  = forced;
        next_state.prev_acquire = acquire;
        capture = (forced & ~state.prev_forced) | (acquire & ~state.prev_acquire);
        if (capture) begin
            next_state.nominal = vcxo_freq_in;
        end

        // failure flags: a new failure wins over a monitor reset
        if (monitor_reset) begin
            next_state.fail_a = 1'b0;
            next_state.fail_b = 1'b0;
            next_state.alert  = 1'b0;
        end
        if (fail_a_pin & ref_a_on) begin
            next_state.fail_a = 1'b1;
            next_state.alert  = 1'b1;
        end
        if (fail_b_pin & ref_b_on) begin
            next_state.fail_b = 1'b1;
            next_state.alert  = 1'b1;
        end

        // reference selection monitor
        case (state.mon)
            mon_use_a: begin
                if (hold_enable & forced) begin
                    next_state.mon = mon_holdover;
                end else if (next_state.fail_a | ~ref_a_on) begin
                    if (ref_b_on & ~next_state.fail_b) begin
                        next_state.mon = mon_use_b;
                    end else if (hold_enable) begin
                        next_state.mon = mon_holdover;
                    end
                end else if (revert & default_b & ref_b_on & ~next_state.fail_b) begin
                    next_state.mon = mon_use_b;
                end
            end
            mon_use_b: begin
                if (hold_enable & forced) begin
                    next_state.mon = mon_holdover;
                end else if (next_state.fail_b | ~ref_b_on) begin
                    if (ref_a_on & ~next_state.fail_a) begin
                        next_state.mon = mon_use_a;
                    end else if (hold_enable) begin
                        next_state.mon = mon_holdover;
                    end
                end else if (revert & ~default_b & ref_a_on & ~next_state.fail_a) begin
                    next_state.mon = mon_use_a;
                end
            end
            mon_holdover: begin
                // leaves holdover once forcing ends and an input is usable, or at once if holdover is disabled
                if (~hold_enable | ~forced) begin
                    if (ref_a_on & ~next_state.fail_a & (~default_b | ~ref_b_on | next_state.fail_b)) begin
                        next_state.mon = mon_use_a;
                    end else if (ref_b_on & ~next_state.fail_b) begin
                        next_state.mon = mon_use_b;
                    end else if (~hold_enable) begin
                        next_state.mon = default_b ? mon_use_b : mon_use_a;
                    end
                end
            end
            default: begin
                next_state.mon = mon_use_a;
            end
        endcase
        if (monitor_reset) begin
            next_state.mon = default_b ? mon_use_b : mon_use_a;
        end

        // clock output pins, high impedance overrides logic low
        next_state.clk_a_oe = state.regs.ctrl_a[pos_enable_a];
        next_state.clk_b_oe = state.regs.ctrl_a[pos_enable_b];
        next_state.clk_a    = div_a & ~out_disable & state.regs.ctrl_a[pos_enable_a];
        next_state.clk_b    = div_b & ~out_disable & state.regs.ctrl_a[pos_enable_b];
        next_state.clk_aux  = (state.regs.ctrl_b[pos_aux_source] ? div_b : div_a) & ~out_disable;

        // soft or pin master reset returns everything to power-up values
        if (state.regs.ctrl_b[pos_soft_reset] | mr_pin) begin
            next_state = state_reset;
        end
    end

    // ----------------------------------------
    // state register
    // ----------------------------------------
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            state <= state_reset;
        end else begin
            state <= next_state;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    always_comb begin
        pll_control_out.ref_ratio         = {1'b0, state.regs.ref_div} + 9'h001;
        pll_control_out.feedback_ratio    = {1'b0, state.regs.fb_one, state.regs.fb_two[7:1]} + 16'h0001;
        pll_control_out.out_a_ratio       = out_ratio(state.regs.out_a[7:5]);
        pll_control_out.out_b_ratio       = out_ratio(state.regs.out_b[7:5]);
        pll_control_out.ref_a_enabled     = ref_a_on;
        pll_control_out.ref_b_enabled     = ref_b_on;
        pll_control_out.use_ref_b         = (state.mon == mon_use_b);
        pll_control_out.holdover          = (state.mon == mon_holdover);
        pll_control_out.hold_value_select = state.regs.ctrl_b[pos_acquire_select];
        pll_control_out.nominal_freq      = state.nominal;
    end

    assign read_data_out         = state.rdata;
    assign read_valid_out        = state.rvalid;
    assign clock_output_a_out    = state.clk_a;
    assign clock_output_a_oe_out = state.clk_a_oe;
    assign clock_output_b_out    = state.clk_b;
    assign clock_output_b_oe_out = state.clk_b_oe;
    assign clock_output_aux_out  = state.clk_aux;
    assign failure_alert_out     = state.alert;
    assign chip_reset_out        = state.regs.ctrl_b[pos_soft_reset] | mr_pin;

endmodule : clock_gen_config_status_regs

//--- tb/clock_gen_regs_assertions.sv
`timescale 1ns/10ps
module clock_gen_regs_checker (
    input wire logic                           clock_in,
    input wire logic                           rst_in,
    input wire clock_gen_pkg::reg_access_type  access_in,
    input wire logic [7:0]                     read_data_out,
    input wire logic                           read_valid_out,
    input wire clock_gen_pkg::pll_control_type pll_control_out,
    input wire logic                           clock_output_a_oe_out,
    input wire logic                           failure_alert_out,
    input wire logic                           chip_reset_out
);
    import clock_gen_pkg::*;
    default clocking @(posedge clock_in);
    endclocking
    default disable iff (rst_in);
    a_read_answered: assert property (access_in.rd |=> read_valid_out) else $error("read not answered");
    a_valid_has_cause: assert property (read_valid_out |-> $past(access_in.rd)) else $error("stray valid");
    a_reserved_zero:
        assert property (access_in.rd && access_in.addr == 8'h08 |=> read_data_out == 8'h00) else $error("rsvd");
    a_status_fields:
        assert property (access_in.rd && access_in.addr == 8'h07 |=> read_data_out[1:0] == 2'h0
            && read_data_out[7] == $past(failure_alert_out) && read_data_out[2] == $past(pll_control_out.holdover)
            && read_data_out[4] == $past(pll_control_out.use_ref_b)) else $error("status fields");
    a_ref_ratio:
        assert property (read_valid_out && $past(access_in.addr) == 8'h00 && !$past(access_in.wr)
            |-> pll_control_out.ref_ratio == {1'b0, read_data_out} + 9'h001) else $error("ref ratio");
    a_out_ratio:
        assert property (read_valid_out && $past(access_in.addr) == 8'h03 && !$past(access_in.wr)
            |-> pll_control_out.out_a_ratio == (read_data_out[7:5] < 3'h6 ? {2'h0, read_data_out[7:5]} + 5'h01
            : read_data_out[7:5] == 3'h6 ? 5'h08 : 5'h10)) else $error("out ratio");
    a_soft_reset:
        assert property (access_in.wr && access_in.addr == 8'h06 && access_in.wdata[4] && !chip_reset_out
            |=> chip_reset_out ##1 pll_control_out.out_a_ratio == 5'h01) else $error("soft reset");
    a_hold_select:
        assert property (access_in.wr && access_in.addr == 8'h06 && !chip_reset_out
            |=> pll_control_out.hold_value_select == $past(access_in.wdata[1])) else $error("hold select");
    a_oe_follows:
        assert property (access_in.wr && access_in.addr == 8'h05 && !chip_reset_out
            |=> ##1 clock_output_a_oe_out == $past(access_in.wdata[6], 2)) else $error("oe a");
endmodule : clock_gen_regs_checker
bind clock_gen_config_status_regs clock_gen_regs_checker chk (.clock_in, .rst_in, .access_in, .read_data_out,
    .read_valid_out, .pll_control_out, .clock_output_a_oe_out, .failure_alert_out, .chip_reset_out);

//--- tb/host_model.sv
`timescale 1ns/10ps
module host_model (
    input  wire logic                     clock_in,
    input  wire logic [7:0]               read_data_in,
    input  wire logic                     read_valid_in,
    output clock_gen_pkg::reg_access_type access_out
);
    import clock_gen_pkg::*;
    initial access_out = '{8'h55, 1'b0, 1'b0, 8'haa};
    // idle lines show the inverse so a stale byte never looks valid
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clock_in);
        access_out = '{a, 1'b1, 1'b0, (a[6:0] == 7'h06) ? (d & 8'hf7) : d};
        @(negedge clock_in);
        access_out = '{~a, 1'b0, 1'b0, ~d};
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clock_in);
        access_out = '{a, 1'b0, 1'b1, 8'h00};
        @(negedge clock_in);
        access_out = '{~a, 1'b0, 1'b0, 8'hff};
        d = read_valid_in ? read_data_in : 8'hxx;
    endtask : rd
endmodule : host_model

//--- tb/tb_clock_gen_config_status_regs.sv
`timescale 1ns/10ps
module tb_clock_gen_config_status_regs;
    import clock_gen_pkg::*;
    logic clock_in, rst_in, tw, mr, sel_a, sel_b, fail_a, fail_b, unl, div_a, div_b;
    logic rvalid, ca, ca_oe, cb, cb_oe, caux, alert, crst;
    logic [15:0] vcxo;
    logic [7:0] rdata, d;
    reg_access_type acc;
    pll_control_type ctl;
    int mismatches, n_compared;
    logic [7:0] wexp [9] = '{8'hff, 8'hff, 8'hfe, 8'he0, 8'he0, 8'hfe, 8'he6, 8'h00, 8'h00};
    logic [4:0] rtab [8] = '{5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h06, 5'h08, 5'h10};
    logic [1:0] etab [4] = '{2'b10, 2'b10, 2'b01, 2'b11};
    clock_gen_config_status_regs dut (.clock_in(clock_in), .rst_in(rst_in), .access_in(acc),
        .three_wire_mode_in(tw), .read_data_out(rdata), .read_valid_out(rvalid), .master_reset_pin_in(mr),
        .select_pin_a_in(sel_a), .select_pin_b_in(sel_b), .ref_input_a_fail_in(fail_a),
        .ref_input_b_fail_in(fail_b), .pll_unlocked_in(unl), .divider_out_a_in(div_a), .divider_out_b_in(div_b),
        .vcxo_freq_in(vcxo), .pll_control_out(ctl), .clock_output_a_out(ca), .clock_output_a_oe_out(ca_oe),
        .clock_output_b_out(cb), .clock_output_b_oe_out(cb_oe), .clock_output_aux_out(caux),
        .failure_alert_out(alert), .chip_reset_out(crst));
    host_model host (.clock_in(clock_in), .read_data_in(rdata), .read_valid_in(rvalid), .access_out(acc));
    always #2.5 clock_in = ~clock_in;
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic rc(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] v;
        host.rd(a, v);
        check($sformatf("reg %h", a), v, e);
    endtask : rc
    task automatic finish_test;
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : finish_test
    initial begin
        #20000;
        mismatches++;
        finish_test;
    end
    initial begin
        {clock_in, tw, mr, sel_b, fail_a, fail_b, unl, div_a} = '0;
        {rst_in, sel_a, div_b} = 3'b111;
        vcxo = 16'h1234;
        repeat (6) @(posedge clock_in);
        @(negedge clock_in) rst_in = 1'b0;
        for (int i = 0; i < 9; i++) rc(8'(i), (i == 5) ? 8'h60 : 8'h00);
        $display("test reset values done");
        for (int i = 0; i < 9; i++) host.wr(8'(i), (i == 6) ? 8'hee : 8'hff);
        repeat (5) @(negedge clock_in);
        check("ref_ratio", ctl.ref_ratio, 9'h100);
        check("fb_ratio", ctl.feedback_ratio, 16'h8000);
        check("clk_a", ca, 1'b0);
        check("clk_b", cb, 1'b0);
        check("clk_aux", caux, 1'b0);
        check("oe_a", ca_oe, 1'b1);
        check("hold", {ctl.holdover, ctl.hold_value_select}, 2'b11);
        check("nominal", ctl.nominal_freq, 16'h1234);
        for (int i = 0; i < 9; i++) if (i != 7) rc(8'(i), wexp[i]);
        $display("test write masks done");
        for (int c = 0; c < 8; c++) begin
            host.wr(8'h03, {3'(c), 5'h1f});
            host.wr(8'h04, {3'(c), 5'h00});
            check("ratio_a", ctl.out_a_ratio, rtab[c]);
            check("ratio_b", ctl.out_b_ratio, rtab[c]);
        end
        host.wr(8'h05, 8'h20);
        repeat (5) @(negedge clock_in);
        check("oe_a", ca_oe, 1'b0);
        check("oe_b", cb_oe, 1'b1);
        check("clk_b", cb, 1'b1);
        check("aux_b", caux, 1'b1);
        host.wr(8'h06, 8'h80);
        repeat (5) @(negedge clock_in);
        check("aux_a", caux, 1'b0);
        for (int m = 0; m < 4; m++) begin
            host.wr(8'h05, 8'h20 | 8'(m << 2));
            check("ref_en", {ctl.ref_a_enabled, ctl.ref_b_enabled}, etab[m]);
        end
        $display("test outputs done");
        {unl, fail_a} = 2'b11;
        repeat (6) @(negedge clock_in);
        host.rd(8'h07, d);
        check("status", d[6:3], 4'b1011);
        fail_a = 1'b0;
        repeat (4) @(negedge clock_in);
        host.wr(8'h05, 8'h2f);
        repeat (2) @(negedge clock_in);
        host.rd(8'h07, d);
        check("mon_reset", d[7:4], 4'h0);
        check("alert", alert, 1'b0);
        $display("test monitor done");
        tw = 1'b1;
        repeat (4) @(negedge clock_in);
        host.wr(8'h80, 8'h5a);
        rc(8'h80, 8'h5a);
        tw = 1'b0;
        repeat (4) @(negedge clock_in);
        rc(8'h80, 8'h00);
        host.wr(8'h06, 8'h10);
        check("chip_reset", crst, 1'b1);
        repeat (3) @(negedge clock_in);
        rc(8'h05, 8'h60);
        host.wr(8'h00, 8'h33);
        mr = 1'b1;
        repeat (4) @(negedge clock_in);
        mr = 1'b0;
        repeat (4) @(negedge clock_in);
        rc(8'h00, 8'h00);
        vcxo = 16'h5678;
        host.wr(8'h06, 8'h20);
        // capture lands one edge after the bit is stored
        @(negedge clock_in);
        check("acquire", ctl.nominal_freq, 16'h5678);
        $display("test resets done");
        finish_test;
    end
endmodule : tb_clock_gen_config_status_regs
